// >>> logic/wdr_regs.svh
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH
`define WDR_CNT_W 10
`define WDR_CNT_INIT 10'h000
`define WDR_CNT_MAX 10'h3ff
`define WDR_CNT_STEP 10'h001
`define WDR_RUN_W 4
`define WDR_RUN_STOP 4'ha
`define WDR_KEY_W 16
`define WDR_KEY_OPEN 16'h0096
`endif

// >>> logic/wdr_pkg.sv
package wdr_pkg;
  typedef enum logic [0:0] {
    WDR_IDLE = 1'b0,
    WDR_RUN = 1'b1
  } wdr_mode_t;

  // Software write port toward the control and protect registers.
  typedef struct packed {
    logic ctl_we;
    logic clear_bit;
    logic [3:0] run_field;
    logic key_we;
    logic [15:0] key_field;
  } wdr_wr_t;

  typedef struct packed {
    wdr_mode_t mode;
    logic [9:0] cnt;
    logic rst_req;
    logic prot_on;
    logic tick_d;
  } wdr_state_t;
endpackage

// >>> logic/wdr_sync.sv
`timescale 1ns/1ps
module wdr_sync (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } wdr_sync_t;

  wdr_sync_t st_r;
  wdr_sync_t st_nxt;

  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// >>> logic/wdr_timer.sv
`timescale 1ns/1ps
`include "wdr_regs.svh"
// What this block does
// [RQ1] A 10-bit up counter counts the reset cycle on the watchdog clock tick.
// [RQ2] Counter overflow raises a system reset request, never an interrupt.
// [RQ3] No non-maskable interrupt output exists under any setting.
// [RQ4] Writing one to the clear bit returns the counter to its start value.
// [RQ5] Run field value other than 0xa starts counting; 0xa keeps it stopped.
// [RQ6] Protect key other than 0x0096 re-engages system register protection.
// [RQ7] Each clear starts a full new cycle; missing the next clear resets.
// [RQ8] Counting continues in HALT; overflow there ends HALT by reset.
// [RQ9] In SLEEP the counter advances only while its clock source ticks.
// [RQ10] Software should clear the counter together with starting it.
// [RQ11] Overflow is the roll from all ones to zero, only while running.
module wdr_timer (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wdt_tick,
  input wdr_pkg::wdr_wr_t wr,
  output logic sys_rst_req,
  output logic running,
  output logic prot_on,
  output logic [9:0] count
);
  wdr_pkg::wdr_state_t st_r;
  wdr_pkg::wdr_state_t st_nxt;
  logic tick_s;
  logic tick_edge;
  logic ctl_take;
  logic clr_take;
  logic run_stop;
  logic key_open;
  logic ovf_hit;

  // The watchdog clock source comes from another domain; it is synchronised
  // and its rising edge is one count, so a stopped source freezes the count.
  // Each level of the source must last more than one system clock or edges are lost.
  wdr_sync u_tick_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(wdt_tick),
    .q(tick_s)
  );

  // The previous synchronised level lives in the state word and resets low
  // like the idle source, so no false edge follows reset.
  assign tick_edge = tick_s & ~st_r.tick_d; // RQ9
  // Control writes land only while system protection is off.
  assign ctl_take = wr.ctl_we && !st_r.prot_on; // RQ6
  assign clr_take = ctl_take && wr.clear_bit; // RQ4
  assign run_stop = (wr.run_field == `WDR_RUN_STOP); // RQ5
  assign key_open = (wr.key_field == `WDR_KEY_OPEN); // RQ6
  assign ovf_hit = (st_r.mode == wdr_pkg::WDR_RUN) && tick_edge
    && (st_r.cnt == `WDR_CNT_MAX); // RQ11

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rst_req = 1'b0;
    st_nxt.tick_d = tick_s;
    if (ctl_take)
    begin
      if (run_stop) // RQ5
      begin
        st_nxt.mode = wdr_pkg::WDR_IDLE;
      end
      else
      begin
        st_nxt.mode = wdr_pkg::WDR_RUN;
      end
    end
    // Counting ignores HALT and SLEEP entirely; only the run mode and the tick gate it, so
    // a source kept alive in either mode keeps the watchdog armed.
    if (st_r.mode == wdr_pkg::WDR_RUN && tick_edge) // RQ8
    begin
      st_nxt.cnt = st_r.cnt + `WDR_CNT_STEP; // RQ1
    end
    if (ovf_hit) // RQ11
    begin
      st_nxt.rst_req = 1'b1; // RQ2
    end
    // A clear wins over a same-cycle tick so a fresh full cycle begins,
    // and the overflow that the tick would have caused is dropped with it.
    if (clr_take) // RQ4
    begin
      st_nxt.cnt = `WDR_CNT_INIT; // RQ7
      st_nxt.rst_req = 1'b0; // RQ7
    end
    if (wr.key_we)
    begin
      st_nxt.prot_on = !key_open; // RQ6
    end
  end

  // Protection comes out of reset engaged, so a runaway program cannot stop
  // the watchdog without first writing the open key.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r.mode <= wdr_pkg::WDR_IDLE;
      st_r.cnt <= `WDR_CNT_INIT;
      st_r.rst_req <= 1'b0;
      st_r.prot_on <= 1'b1;
      st_r.tick_d <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // There is deliberately no interrupt port of any kind.
  assign sys_rst_req = st_r.rst_req; // RQ3
  assign running = (st_r.mode == wdr_pkg::WDR_RUN);
  assign prot_on = st_r.prot_on;
  assign count = st_r.cnt;

  // The properties watch the registered outputs, not the next state.
  property ovf_reset_p;
    @(posedge clk_sys) disable iff (srst)
    (running && tick_edge && count == `WDR_CNT_MAX
      && !(wr.ctl_we && !prot_on && wr.clear_bit)) |=> sys_rst_req;
  endproperty
  ovf_reset_a: assert property (ovf_reset_p) // RQ2
    else $error("overflow did not raise reset");

  property req_cause_p;
    @(posedge clk_sys) disable iff (srst)
    sys_rst_req |-> $past(running) && $past(count) == `WDR_CNT_MAX;
  endproperty
  req_cause_a: assert property (req_cause_p) // RQ11
    else $error("reset without overflow");

  property clear_zero_p;
    @(posedge clk_sys) disable iff (srst)
    (wr.ctl_we && !prot_on && wr.clear_bit) |=> count == `WDR_CNT_INIT;
  endproperty
  clear_zero_a: assert property (clear_zero_p) // RQ4
    else $error("clear did not zero counter");

  property stop_key_p;
    @(posedge clk_sys) disable iff (srst)
    (wr.ctl_we && !prot_on) |=>
      running == ($past(wr.run_field) != `WDR_RUN_STOP);
  endproperty
  stop_key_a: assert property (stop_key_p) // RQ5
    else $error("run field decode wrong");

  property prot_key_p;
    @(posedge clk_sys) disable iff (srst)
    wr.key_we |=> prot_on == ($past(wr.key_field) != `WDR_KEY_OPEN);
  endproperty
  prot_key_a: assert property (prot_key_p) // RQ6
    else $error("protect key decode wrong");

  property count_step_p;
    @(posedge clk_sys) disable iff (srst)
    (running && tick_edge && !wr.ctl_we) |=>
      count == $past(count) + `WDR_CNT_STEP;
  endproperty
  count_step_a: assert property (count_step_p) // RQ1
    else $error("counter did not step");

  property freeze_p;
    @(posedge clk_sys) disable iff (srst)
    (!tick_edge && !wr.ctl_we) |=> $stable(count);
  endproperty
  freeze_a: assert property (freeze_p) // RQ9
    else $error("counter moved without tick");

  property idle_hold_p;
    @(posedge clk_sys) disable iff (srst)
    (!running && !wr.ctl_we)[*2] |-> !sys_rst_req;
  endproperty
  idle_hold_a: assert property (idle_hold_p) // RQ7
    else $error("reset while stopped");

  property locked_ignore_p;
    @(posedge clk_sys) disable iff (srst)
    (wr.ctl_we && prot_on && !tick_edge) |=>
      $stable(running) && $stable(count);
  endproperty
  locked_ignore_a: assert property (locked_ignore_p) // RQ6
    else $error("locked control write took effect");

  property single_pulse_p;
    @(posedge clk_sys) disable iff (srst)
    sys_rst_req |=> !sys_rst_req;
  endproperty
  single_pulse_a: assert property (single_pulse_p) // RQ2
    else $error("reset request longer than one cycle");

  property wrap_zero_p;
    @(posedge clk_sys) disable iff (srst)
    sys_rst_req |-> count == `WDR_CNT_INIT;
  endproperty
  wrap_zero_a: assert property (wrap_zero_p) // RQ11
    else $error("counter did not wrap on overflow");

  property clear_fresh_p;
    @(posedge clk_sys) disable iff (srst)
    (wr.ctl_we && !prot_on && wr.clear_bit) |=> !sys_rst_req;
  endproperty
  clear_fresh_a: assert property (clear_fresh_p) // RQ7
    else $error("reset right after a clear");

  property stopped_freeze_p;
    @(posedge clk_sys) disable iff (srst)
    (!running && !wr.ctl_we) |=> $stable(count);
  endproperty
  stopped_freeze_a: assert property (stopped_freeze_p) // RQ5
    else $error("counter moved while stopped");

  // Covers mark the scenarios that the bench is expected to reach.
  ovf_c: cover property (@(posedge clk_sys) disable iff (srst) sys_rst_req);
  start_c: cover property (@(posedge clk_sys) disable iff (srst)
    !running ##1 running);
  clear_c: cover property (@(posedge clk_sys) disable iff (srst)
    running && wr.ctl_we && wr.clear_bit && !prot_on);
  locked_c: cover property (@(posedge clk_sys) disable iff (srst)
    wr.ctl_we && prot_on);
  stop_tick_c: cover property (@(posedge clk_sys) disable iff (srst)
    !running && tick_edge);
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys;
  logic srst;
  logic wdt_tick;
  wdr_pkg::wdr_wr_t wr;
  logic sys_rst_req;
  logic running;
  logic prot_on;
  logic [9:0] count;
  int num_errors;
  int checked;
  int pulses;
  int p0;

  wdr_timer dut (.clk_sys(clk_sys), .srst(srst), .wdt_tick(wdt_tick),
    .wr(wr), .sys_rst_req(sys_rst_req), .running(running),
    .prot_on(prot_on), .count(count));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (srst)
      pulses <= 0;
    else if (sys_rst_req === 1'b1)
      pulses <= pulses + 1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr_ctl(input logic clr, input logic [3:0] run);
    @(posedge clk_sys);
    wr.ctl_we <= 1'b1;
    wr.clear_bit <= clr;
    wr.run_field <= run;
    @(posedge clk_sys);
    wr.ctl_we <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic wr_key(input logic [15:0] k);
    @(posedge clk_sys);
    wr.key_we <= 1'b1;
    wr.key_field <= k;
    @(posedge clk_sys);
    wr.key_we <= 1'b0;
    @(negedge clk_sys);
  endtask

  // Tick high phases of three clocks and low phases of four, longer than the one clock the sampler needs.
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      wdt_tick <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wdt_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    @(negedge clk_sys);
  endtask

  task automatic t_protect_stop();
    chk(prot_on, 1);
    wr_ctl(1'b1, 4'h5);
    chk(running, 0);
    wr_key(16'h0096);
    chk(prot_on, 0);
    wr_ctl(1'b1, 4'ha);
    tick(2);
    chk(running, 0);
    chk(count, 0);
  endtask

  task automatic t_count_clear();
    wr_ctl(1'b1, 4'h0);
    chk(running, 1);
    tick(5);
    chk(count, 5);
    repeat (20) @(negedge clk_sys);
    chk(count, 5);
    wr_key(16'h0000);
    chk(prot_on, 1);
    wr_ctl(1'b1, 4'h3);
    chk(count, 5);
    wr_key(16'h0096);
    wr_ctl(1'b1, 4'h3);
    chk(count, 0);
  endtask

  task automatic t_overflow();
    p0 = pulses;
    tick(1023);
    chk(count, 10'h3ff);
    chk(pulses, p0);
    tick(1);
    chk(pulses, p0 + 1);
    chk(count, 0);
    chk(running, 1);
  endtask

  task automatic t_mid_reset();
    tick(3);
    chk(count, 3);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    chk(running, 0);
    chk(count, 0);
    chk(prot_on, 1);
    chk(sys_rst_req, 0);
  endtask

  initial
  begin
    srst = 1'b1;
    wdt_tick = 1'b0;
    wr = '0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    t_protect_stop();
    t_count_clear();
    t_overflow();
    t_mid_reset();
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule
